// File: gpio_port_pkg.sv
// gpio_port_pkg: constants, register map and carrier types of the gpio port
package gpio_port_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int PINS = 16;
    localparam int IRQ_PINS = 13;
    localparam int TYPE_W = 3;
    localparam int TYPE_LO_PINS = 8;
    localparam int TYPE_HI_PINS = IRQ_PINS - TYPE_LO_PINS;
    localparam int CLK_PIN_LO = 14;
    localparam int CLK_PIN_HI = 15;
    localparam int USB_ALT_PIN = 1;
    localparam int DIV_W = 8;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_OUT = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_IN = 8'h08;
    localparam logic [7:0] OFS_TYPE_LO = 8'h0c;
    localparam logic [7:0] OFS_TYPE_HI = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_CLKCFG = 8'h1c;
    localparam logic [7:0] OFS_CLKSEL = 8'h20;
    localparam logic [7:0] OFS_ALT = 8'h24;

    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [15:0] OUT_RESET = 16'h0000;
    localparam logic [15:0] DIR_RESET = 16'h0000;
    localparam logic [15:0] CLKSEL_RESET = 16'h8000;
    localparam logic [15:0] CLKSEL_WMASK = 16'hc000;
    localparam logic [7:0] CLKDIV_RESET = 8'h00;
    localparam logic [12:0] MASK_RESET = 13'h0000;
    localparam int ALT_USB_BIT = 0;

    // detection type codes, one 3-bit field per interrupt pin 0..12
    localparam logic [2:0] DET_HIGH = 3'h0;
    localparam logic [2:0] DET_LOW = 3'h1;
    localparam logic [2:0] DET_RISE = 3'h2;
    localparam logic [2:0] DET_FALL = 3'h3;
    localparam logic [2:0] DET_ANY = 3'h4;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLOCK_KHZ = 10000;
    localparam int CLKOUT_MAX_KHZ = 33330;
    localparam int HALF_CYC_RAW = (CLOCK_KHZ + 2 * CLKOUT_MAX_KHZ - 1) / (2 * CLKOUT_MAX_KHZ);
    localparam int CLKOUT_MIN_HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [15:0] dout;
        logic [15:0] oe;
    } pad_drive_t;

endpackage : gpio_port_pkg

// File: gpio_clkgen.sv
// gpio_clkgen: divider that makes the programmable pin clock
`timescale 1ns/1ps
module gpio_clkgen (
    input wire logic clock,                           // device clock
    input wire logic rst,                             // async reset, high
    input wire logic ce,                              // clock enable
    input wire logic run,                             // some pin selects the clock
    input wire logic [gpio_port_pkg::DIV_W-1:0] half, // half period minus one
    output logic clk_out                              // divided clock
);
    import gpio_port_pkg::*;

    localparam logic [DIV_W-1:0] MIN_LIMIT = DIV_W'(CLKOUT_MIN_HALF_CYC - 1);

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] limit;

    // never shorter than the fastest legal half period
    assign limit = (half < MIN_LIMIT) ? MIN_LIMIT : half;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            clk_out <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt <= '0;
                clk_out <= 1'b0;
            end else if (cnt >= limit) begin
                cnt <= '0;
                clk_out <= ~clk_out;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    clk_half_period_a: assert property (@(posedge clock) disable iff (rst)
        (ce && $past(ce) && run && $past(run) && $changed(clk_out)) |-> ($past(cnt) >= $past(limit)))
        else $error("divided clock toggled before its minimum half period");

endmodule : gpio_clkgen

// File: gpio_port.sv
// gpio_port: sixteen-pin gpio port with interrupts, clock out and apb registers
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module gpio_port (
    input wire logic clock,                              // device clock, 10 MHz
    input wire logic rst,                                // async reset, high
    input wire logic ce,                                 // clock enable, low freezes all state
    input wire gpio_port_pkg::apb_req_t apb_req,         // apb request from master
    output gpio_port_pkg::apb_rsp_t apb_rsp,             // apb answer to master
    input wire logic [gpio_port_pkg::PINS-1:0] pad_in,   // pin levels as seen at the pads
    output gpio_port_pkg::pad_drive_t pad,               // pin drive values and enables
    output logic usb_bypass_clk,                         // bypass clock handed to usb logic
    output logic irq                                     // level interrupt, high active
);
    import gpio_port_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [PINS-1:0] out_data;
    logic [PINS-1:0] dir;
    logic [PINS-1:0] clksel;
    logic [IRQ_PINS*TYPE_W-1:0] itype;
    logic [IRQ_PINS-1:0] status;
    logic [IRQ_PINS-1:0] mask;
    logic [DIV_W-1:0] clkdiv;
    logic alt_usb;
    logic [PINS-1:0] prev_in;
    logic [31:0] rd_data;
    logic clk_out;

    logic [IRQ_PINS-1:0] event_hit;
    logic [PINS-1:0] next_oe;
    logic [PINS-1:0] next_dout;
    logic [31:0] next_rd;
    logic mapped;
    logic wr_en;
    logic setup;

    // ************************************************************
    // apb slave
    // ************************************************************
    // zero wait states: every access phase completes at its first edge
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && mapped && ce;

    always_comb begin
        mapped = 1'b1;
        next_rd = 32'h0000_0000;
        unique case (apb_req.paddr)
            OFS_OUT: next_rd[PINS-1:0] = out_data;
            OFS_DIR: next_rd[PINS-1:0] = dir;
            OFS_IN: next_rd[PINS-1:0] = pad_in;
            OFS_TYPE_LO: next_rd[TYPE_LO_PINS*TYPE_W-1:0] = itype[TYPE_LO_PINS*TYPE_W-1:0];
            OFS_TYPE_HI: next_rd[TYPE_HI_PINS*TYPE_W-1:0] = itype[IRQ_PINS*TYPE_W-1:TYPE_LO_PINS*TYPE_W];
            OFS_STATUS: next_rd[IRQ_PINS-1:0] = status;
            OFS_MASK: next_rd[IRQ_PINS-1:0] = mask;
            OFS_CLKCFG: next_rd[DIV_W-1:0] = clkdiv;
            OFS_CLKSEL: next_rd[PINS-1:0] = clksel;
            OFS_ALT: next_rd[ALT_USB_BIT] = alt_usb;
            default: mapped = 1'b0;
        endcase
    end

    // read data is caught in the setup cycle so it comes from a flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data <= 32'h0000_0000;
        end else if (ce && setup) begin
            rd_data <= next_rd;
        end
    end

    always_comb begin
        apb_rsp.prdata = rd_data;
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
    end

    // ************************************************************
    // output data and direction
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_data <= OUT_RESET;
        end else if (wr_en && apb_req.paddr == OFS_OUT) begin
            out_data <= apb_req.pwdata[PINS-1:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dir <= DIR_RESET;
        end else if (wr_en && apb_req.paddr == OFS_DIR) begin
            dir <= apb_req.pwdata[PINS-1:0];
        end
    end

    // ************************************************************
    // clock out selection and divider
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clksel <= CLKSEL_RESET;
        end else if (wr_en && apb_req.paddr == OFS_CLKSEL) begin
            clksel <= apb_req.pwdata[PINS-1:0] & CLKSEL_WMASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkdiv <= CLKDIV_RESET;
        end else if (wr_en && apb_req.paddr == OFS_CLKCFG) begin
            clkdiv <= apb_req.pwdata[DIV_W-1:0];
        end
    end

    gpio_clkgen clkgen (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .run(|clksel),
        .half(clkdiv),
        .clk_out(clk_out)
    );

    // ************************************************************
    // pad drive
    // ************************************************************
    // a pin drives when set as output or when it carries the clock
    always_comb begin
        next_oe = dir | clksel;
        next_dout = out_data;
        next_dout[CLK_PIN_LO] = clksel[CLK_PIN_LO] ? clk_out : out_data[CLK_PIN_LO];
        next_dout[CLK_PIN_HI] = clksel[CLK_PIN_HI] ? clk_out : out_data[CLK_PIN_HI];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pad.oe <= DIR_RESET | CLKSEL_RESET;
            pad.dout <= OUT_RESET;
        end else if (ce) begin
            pad.oe <= next_oe;
            pad.dout <= next_dout;
        end
    end

    // ************************************************************
    // usb bypass clock
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alt_usb <= 1'b0;
        end else if (wr_en && apb_req.paddr == OFS_ALT) begin
            alt_usb <= apb_req.pwdata[ALT_USB_BIT];
        end
    end

    // clock path, not data: a flop at 10 MHz could not carry 48 MHz
    assign usb_bypass_clk = alt_usb && !next_oe[USB_ALT_PIN] && pad_in[USB_ALT_PIN];

    // ************************************************************
    // interrupt detection
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_in <= '0;
        end else if (ce) begin
            prev_in <= pad_in;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            itype <= '0;
        end else if (wr_en && apb_req.paddr == OFS_TYPE_LO) begin
            itype[TYPE_LO_PINS*TYPE_W-1:0] <= apb_req.pwdata[TYPE_LO_PINS*TYPE_W-1:0];
        end else if (wr_en && apb_req.paddr == OFS_TYPE_HI) begin
            itype[IRQ_PINS*TYPE_W-1:TYPE_LO_PINS*TYPE_W] <= apb_req.pwdata[TYPE_HI_PINS*TYPE_W-1:0];
        end
    end

    // only pins 0..12 have a detector, gated by input direction
    for (genvar i = 0; i < IRQ_PINS; i++) begin : g_det
        logic [TYPE_W-1:0] kind;
        logic hit;
        assign kind = itype[i*TYPE_W +: TYPE_W];
        always_comb begin
            unique case (kind)
                DET_HIGH: hit = pad_in[i];
                DET_LOW: hit = !pad_in[i];
                DET_RISE: hit = pad_in[i] && !prev_in[i];
                DET_FALL: hit = !pad_in[i] && prev_in[i];
                DET_ANY: hit = pad_in[i] != prev_in[i];
                default: hit = 1'b0;
            endcase
        end
        assign event_hit[i] = hit && !next_oe[i];

        edge_sets_status_a: assert property (@(posedge clock) disable iff (rst)
            (ce && !next_oe[i] && kind == DET_RISE && pad_in[i] && !prev_in[i]) |=> status[i])
            else $error("rising edge on an input pin did not set its status bit");

        level_sets_status_a: assert property (@(posedge clock) disable iff (rst)
            (ce && !next_oe[i] && kind == DET_HIGH && pad_in[i]) |=> status[i])
            else $error("high level on an input pin did not set its status bit");

        low_sets_status_a: assert property (@(posedge clock) disable iff (rst)
            (ce && !next_oe[i] && kind == DET_LOW && !pad_in[i]) |=> status[i])
            else $error("low level on an input pin did not set its status bit");

        fall_sets_status_a: assert property (@(posedge clock) disable iff (rst)
            (ce && !next_oe[i] && kind == DET_FALL && !pad_in[i] && prev_in[i]) |=> status[i])
            else $error("falling edge on an input pin did not set its status bit");

        bad_code_quiet_a: assert property (@(posedge clock) disable iff (rst)
            (kind > DET_ANY) |-> !event_hit[i])
            else $error("reserved detection code raised an event");
    end

    // ************************************************************
    // status, mask and interrupt output
    // ************************************************************
    // an event in the cycle of a clear wins over the clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else if (ce) begin
            if (wr_en && apb_req.paddr == OFS_STATUS) begin
                status <= (status & ~apb_req.pwdata[IRQ_PINS-1:0]) | event_hit;
            end else begin
                status <= status | event_hit;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask <= MASK_RESET;
        end else if (wr_en && apb_req.paddr == OFS_MASK) begin
            mask <= apb_req.pwdata[IRQ_PINS-1:0];
        end
    end

    assign irq = |(status & mask);

    // ************************************************************
    // checks
    // ************************************************************
    out_pins_follow_a: assert property (@(posedge clock) disable iff (rst)
        (ce && !clksel[CLK_PIN_LO] && !clksel[CLK_PIN_HI]) |=> (pad.dout == $past(out_data)))
        else $error("pad data does not follow the output register");

    dir_drives_oe_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_DIR && apb_req.pwdata[CLK_PIN_HI:0] != 16'h0000)
        |=> ##1 ((pad.oe & $past(apb_req.pwdata[PINS-1:0], 2)) == $past(apb_req.pwdata[PINS-1:0], 2)
        || !$past(ce)))
        else $error("direction write did not enable the pad drivers");

    no_output_event_a: assert property (@(posedge clock) disable iff (rst)
        ce |=> ((status & ~$past(status) & $past(next_oe[IRQ_PINS-1:0])) == 13'h0000))
        else $error("status set on a pin that drives");

    clock_on_pin_a: assert property (@(posedge clock) disable iff (rst)
        (ce && clksel[CLK_PIN_LO]) |=> (pad.dout[CLK_PIN_LO] == $past(clk_out) && pad.oe[CLK_PIN_LO]))
        else $error("pin 14 does not carry the divided clock");

    reset_inputs_a: assert property (@(posedge clock)
        $fell(rst) |-> (dir == DIR_RESET && pad.oe[CLK_PIN_LO-1:0] == 14'h0000 && !pad.oe[CLK_PIN_LO]))
        else $error("pins not inputs after reset");

    reset_clock_pin_a: assert property (@(posedge clock)
        $fell(rst) |-> (pad.oe[CLK_PIN_HI] && clksel[CLK_PIN_HI] && !clksel[CLK_PIN_LO]))
        else $error("pin 15 is not driving the clock after reset");

    usb_bypass_path_a: assert property (@(posedge clock) disable iff (rst)
        (alt_usb && !next_oe[USB_ALT_PIN]) |-> (usb_bypass_clk == pad_in[USB_ALT_PIN]))
        else $error("bypass clock does not follow pin 1");

    status_sticky_a: assert property (@(posedge clock) disable iff (rst)
        (status != 13'h0000 && !(wr_en && apb_req.paddr == OFS_STATUS))
        |=> ((status & $past(status)) == $past(status)))
        else $error("status bit dropped without a clear");

    irq_level_a: assert property (@(posedge clock) disable iff (rst)
        irq == ((status & mask) != 13'h0000))
        else $error("interrupt does not match the enabled status bits");

    ce_freeze_a: assert property (@(posedge clock) disable iff (rst)
        !ce |=> ($stable(status) && $stable(pad.dout) && $stable(pad.oe)))
        else $error("state moved while clock enable was low");

    dropped_write_a: assert property (@(posedge clock) disable iff (rst)
        (!ce && apb_req.psel && apb_req.penable && apb_req.pwrite) |=> ($stable(out_data) && $stable(dir)))
        else $error("register write taken while clock enable was low");

    dir_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_DIR) |=> (dir == $past(apb_req.pwdata[PINS-1:0])))
        else $error("direction write did not land");

    out_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_OUT) |=> (out_data == $past(apb_req.pwdata[PINS-1:0])))
        else $error("output data write did not land");

    oe_follows_a: assert property (@(posedge clock) disable iff (rst)
        ce |=> (pad.oe == $past(dir | clksel)))
        else $error("pad enables do not follow direction and clock select");

    read_back_a: assert property (@(posedge clock) disable iff (rst)
        (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == OFS_DIR && $past(ce && setup))
        |-> (apb_rsp.prdata == {16'h0000, dir}))
        else $error("direction read back does not match the register");

    clock_pins_only_a: assert property (@(posedge clock) disable iff (rst)
        clksel[CLK_PIN_LO-1:0] == 14'h0000)
        else $error("clock selected on a pin other than 14 or 15");

    clock_on_top_a: assert property (@(posedge clock) disable iff (rst)
        (ce && clksel[CLK_PIN_HI]) |=> (pad.dout[CLK_PIN_HI] == $past(clk_out) && pad.oe[CLK_PIN_HI]))
        else $error("pin 15 does not carry the divided clock");

    bypass_off_a: assert property (@(posedge clock) disable iff (rst)
        !alt_usb |-> !usb_bypass_clk)
        else $error("bypass clock active while the alternate function is off");

    status_clear_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_STATUS && event_hit == 13'h0000)
        |=> ((status & $past(apb_req.pwdata[IRQ_PINS-1:0])) == 13'h0000))
        else $error("write one did not clear the status bit");

    clear_loses_a: assert property (@(posedge clock) disable iff (rst)
        (ce && event_hit != 13'h0000) |=> ((status & $past(event_hit)) == $past(event_hit)))
        else $error("event lost against a status clear");

    mask_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_MASK) |=> (mask == $past(apb_req.pwdata[IRQ_PINS-1:0])))
        else $error("mask write did not land");

endmodule : gpio_port

// File: gpio_board.sv
// gpio_board: board-side model of the sixteen gpio pads
`timescale 1ns/1ps
module gpio_board
    import gpio_port_pkg::*;
(
    input wire gpio_port_pkg::pad_drive_t pad,  // device drive values and enables
    input wire logic [15:0] drv_en,             // board drives the pin
    input wire logic [15:0] drv_val,            // board drive value
    output logic [15:0] pad_in                  // resolved pin levels
);
    // ************************************************************
    // pin resolution
    // ************************************************************
    // undriven pins float to the 10k pull-up level, never hold old data
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (pad.oe[i]) begin
                pad_in[i] = pad.dout[i];
            end else if (drv_en[i]) begin
                pad_in[i] = drv_val[i];
            end else begin
                pad_in[i] = 1'b1;
            end
        end
    end
endmodule : gpio_board

// File: tb.sv
// tb: self-checking bench of the gpio port
`timescale 1ns/1ps
module tb;
    import gpio_port_pkg::*;
    logic clock;
    logic rst;
    logic ce;
    apb_req_t req;
    apb_rsp_t rsp;
    pad_drive_t pad;
    logic [15:0] pad_in;
    logic [15:0] drv_en;
    logic [15:0] drv_val;
    logic usb_clk;
    logic irq;
    logic [31:0] rd;
    logic err;
    int bad_count;
    int cmp_count;
    int cycles;
    int n;

    gpio_port dut_u (.clock(clock), .rst(rst), .ce(ce), .apb_req(req), .apb_rsp(rsp), .pad_in(pad_in),
                     .pad(pad), .usb_bypass_clk(usb_clk), .irq(irq));
    gpio_board board_u (.pad(pad), .drv_en(drv_en), .drv_val(drv_val), .pad_in(pad_in));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one apb transfer, then one idle edge so no signal is assigned twice in a time step
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        req.paddr <= a;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.pwdata <= d;
        @(posedge clock);
        req.penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clock);
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // pin 0 goes v0 -> v1 under detection type t; status and irq compared after
    task ev_case(input logic [2:0] t, input logic v0, input logic v1, input logic st, input logic iq);
        drv_val[0] <= v0;
        @(posedge clock);
        wr(OFS_TYPE_LO, 32'({{7{DET_LOW}}, t}));
        wr(OFS_STATUS, 32'h1fff);
        drv_val[0] <= v1;
        repeat (3) @(posedge clock);
        check(32'(irq), 32'(iq));
        rdchk(OFS_STATUS, 32'(st));
        wr(OFS_STATUS, 32'h1fff);
    endtask : ev_case

    // cycles that pin p stays high in one clock-out period
    task half_len(input int p);
        int k;
        k = 0;
        n = 0;
        while (pad.dout[p] !== 1'b0 && k < 64) begin @(posedge clock); k++; end
        while (pad.dout[p] !== 1'b1 && k < 64) begin @(posedge clock); k++; end
        while (pad.dout[p] === 1'b1 && k < 64) begin @(posedge clock); k++; n++; end
        if (k >= 64) begin
            check(32'(k), 32'h0);
        end
    endtask : half_len

    // ************************************************************
    // scenarios
    // ************************************************************
    task test_reset;
        check(32'(pad.oe), 32'h8000);
        check(32'(irq), 32'h0);
        rdchk(OFS_DIR, 32'h0);
        rdchk(OFS_OUT, 32'h0);
        rdchk(OFS_CLKSEL, 32'h8000);
        rdchk(OFS_MASK, 32'h0);
        rdchk(OFS_STATUS, 32'h1fff);
        rdchk(8'h30, 32'h0);
        check(32'(err), 32'h1);
        $display("test reset done");
    endtask : test_reset

    task test_dir;
        wr(OFS_DIR, 32'h0f0f);
        wr(OFS_OUT, 32'h0a0a);
        @(posedge clock);
        check(32'(pad.oe), 32'h8f0f);
        check(32'(pad.dout[14:0]), 32'h0a0a);
        xfer(OFS_IN, 1'b0, 32'h0);
        check(rd & 32'h7fff, 32'h7afa);
        rdchk(OFS_DIR, 32'h0f0f);
        wr(OFS_DIR, 32'h0);
        $display("test dir done");
    endtask : test_dir

    task test_irq;
        wr(OFS_TYPE_HI, 32'({5{DET_LOW}}));
        wr(OFS_MASK, 32'h1);
        drv_en <= 16'h0001;
        ev_case(DET_HIGH, 1'b0, 1'b1, 1'b1, 1'b1);
        ev_case(DET_LOW, 1'b1, 1'b0, 1'b1, 1'b1);
        ev_case(DET_RISE, 1'b0, 1'b1, 1'b1, 1'b1);
        ev_case(DET_RISE, 1'b1, 1'b0, 1'b0, 1'b0);
        ev_case(DET_FALL, 1'b1, 1'b0, 1'b1, 1'b1);
        ev_case(DET_FALL, 1'b0, 1'b1, 1'b0, 1'b0);
        ev_case(DET_ANY, 1'b1, 1'b0, 1'b1, 1'b1);
        ev_case(3'h5, 1'b0, 1'b1, 1'b0, 1'b0);
        wr(OFS_MASK, 32'h0);
        ev_case(DET_ANY, 1'b0, 1'b1, 1'b1, 1'b0);
        drv_en <= 16'h0000;
        wr(OFS_OUT, 32'h1);
        wr(OFS_DIR, 32'h1);
        ev_case(DET_HIGH, 1'b0, 1'b1, 1'b0, 1'b0);
        wr(OFS_DIR, 32'h0);
        $display("test irq done");
    endtask : test_irq

    task test_clkout;
        wr(OFS_CLKCFG, 32'h3);
        half_len(CLK_PIN_HI);
        check(32'(n), 32'h4);
        wr(OFS_CLKCFG, 32'h0);
        half_len(CLK_PIN_HI);
        check(32'(n), 32'(CLKOUT_MIN_HALF_CYC));
        wr(OFS_CLKSEL, 32'h4000);
        @(posedge clock);
        check(32'(pad.oe), 32'h4000);
        half_len(CLK_PIN_LO);
        check(32'(n), 32'h1);
        wr(OFS_CLKSEL, 32'hffff);
        rdchk(OFS_CLKSEL, 32'hc000);
        wr(OFS_CLKSEL, 32'h0);
        @(posedge clock);
        check(32'(pad.oe), 32'h0);
        $display("test clkout done");
    endtask : test_clkout

    task test_usb;
        drv_en <= 16'h0002;
        wr(OFS_ALT, 32'h1);
        drv_val[1] <= 1'b1;
        repeat (2) @(posedge clock);
        check(32'(usb_clk), 32'h1);
        drv_val[1] <= 1'b0;
        repeat (2) @(posedge clock);
        check(32'(usb_clk), 32'h0);
        drv_val[1] <= 1'b1;
        wr(OFS_ALT, 32'h0);
        check(32'(usb_clk), 32'h0);
        $display("test usb done");
    endtask : test_usb

    // writes made while the clock enable is low must be dropped
    task test_freeze;
        wr(OFS_OUT, 32'h0);
        ce <= 1'b0;
        wr(OFS_OUT, 32'h0001);
        wr(OFS_DIR, 32'h0001);
        ce <= 1'b1;
        repeat (2) @(posedge clock);
        check(32'(pad.oe), 32'h0);
        rdchk(OFS_DIR, 32'h0);
        rdchk(OFS_OUT, 32'h0);
        $display("test freeze done");
    endtask : test_freeze

    // ************************************************************
    // main sequence and hang guard
    // ************************************************************
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles >= 20000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        drv_en = 16'h0;
        drv_val = 16'h0;
        bad_count = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        test_reset();
        test_dir();
        test_irq();
        test_clkout();
        test_usb();
        test_freeze();
        final_report();
    end
endmodule : tb
